/* bench/ppu_core_tb.sv */
// Self-checking testbench for the parallel port input unit
`timescale 1ns/100ps
`default_nettype none
module ppu_core_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  wire logic strobe_n, autofd_n, init_n, selectin_n;
  wire logic [7:0] pdata;
  logic busy_pin, ack_n_pin, select_pin, perror_pin, fault_n_pin, dma_req;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic rd_d = 1'b0;
  logic [63:0] expq[$];
  logic [7:0] d;
  // ****************************************************************
  // Clock, host model, device
  // ****************************************************************
  always #5 sys_clk = ~sys_clk;
  ppu_host host (.sys_clk(sys_clk), .strobe_n(strobe_n), .autofd_n(autofd_n),
    .init_n(init_n), .selectin_n(selectin_n), .pdata(pdata));
  ppu_core dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .strobe_n_pin(strobe_n),
    .autofd_n_pin(autofd_n), .init_n_pin(init_n), .selectin_n_pin(selectin_n),
    .pdata_pin(pdata), .busy_pin(busy_pin), .ack_n_pin(ack_n_pin), .select_pin(select_pin),
    .perror_pin(perror_pin), .fault_n_pin(fault_n_pin), .dma_req(dma_req));
  // ****************************************************************
  // Compare tasks and bus tasks
  // ****************************************************************
  task automatic summarize();
    begin
      $display("Compared %0d, mismatched %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask : summarize
  task automatic chk(input string n, input logic e, input logic g);
    begin
      cmp_count++;
      if (g !== e)
      begin
        fail_count++;
        $display("BAD %s expected %b seen %b", n, e, g);
      end
    end
  endtask : chk
  task automatic chk_n(input string n, input int e, input int g);
    begin
      cmp_count++;
      if (g != e)
      begin
        fail_count++;
        $display("BAD %s expected %0d seen %0d", n, e, g);
      end
    end
  endtask : chk_n
  task automatic chk_rd(input logic [63:0] e);
    begin
      cmp_count++;
      if ((reg_rdata & e[63:32]) !== e[31:0])
      begin
        fail_count++;
        $display("BAD reg_rdata expected %h seen %h", e[31:0], reg_rdata);
      end
    end
  endtask : chk_rd
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
    end
  endtask : wr
  // Expected word noted first; the monitor compares it when data stands
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] v);
    begin
      expq.push_back({m, v});
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
    end
  endtask : rd
  task automatic settle(input int n);
    begin
      repeat (n) @(negedge sys_clk);
    end
  endtask : settle
  // Looks for an ack pulse, then measures its width; bounded both ways
  task automatic ack_chk(input logic e);
    int n;
    int w;
    begin
      n = 0;
      w = 0;
      while (ack_n_pin !== 1'b0 && n < 150)
      begin
        @(negedge sys_clk);
        n++;
      end
      while (ack_n_pin === 1'b0 && w < 200)
      begin
        @(negedge sys_clk);
        w++;
      end
      chk("ack_seen", e, n < 150);
      if (e)
        chk_n("ack_width", ppu_pkg::ACK_CYC, w);
    end
  endtask : ack_chk
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    rd_d <= reg_rd;
    if (rd_d && expq.size() > 0)
      chk_rd(expq.pop_front());
    if (cyc == 20000)
    begin
      fail_count++;
      summarize();
    end
  end
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    void'($urandom(59));
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rd(ppu_pkg::ADDR_IO, 32'h3FFF, 32'h0200);
    rd(ppu_pkg::ADDR_CTRL, 32'h0FF, 32'h000);
    settle(2);
    chk("busy_pin", 1'b1, busy_pin);
    wr(ppu_pkg::ADDR_IO, 32'h3800);
    settle(3);
    chk("busy_pin", 1'b0, busy_pin);
    chk("select_pin", 1'b1, select_pin);
    chk("perror_pin", 1'b1, perror_pin);
    chk("fault_n_pin", 1'b0, fault_n_pin);
    rd(ppu_pkg::ADDR_STAT, 32'h3F, 32'h2F);
    wr(ppu_pkg::ADDR_IO, 32'h0);
    for (int m = 0; m < 4; m++)
    begin
      wr(ppu_pkg::ADDR_CTRL, 32'h20);
      wr(ppu_pkg::ADDR_CTRL, 32'(m));
      rd(ppu_pkg::ADDR_CTRL, 32'hFFF, 32'hF00 | 32'(m));
      d = 8'($urandom);
      host.send(d, 1'b1, 4);
      chk("dma_req", m != 0, dma_req);
      chk("busy_pin", m == 1, busy_pin);
      rd(ppu_pkg::ADDR_IO, 32'h1FF, {23'h0, 1'b1, d});
      ack_chk(m == 1);
    end
    d = 8'($urandom) & 8'h7F;
    host.send(d, 1'b0, 4);
    rd(ppu_pkg::ADDR_CTRL, 32'h0FF, 32'h0C3);
    wr(ppu_pkg::ADDR_CTRL, 32'h20);
    rd(ppu_pkg::ADDR_CTRL, 32'h0FF, 32'h000);
    wr(ppu_pkg::ADDR_CTRL, 32'h1);
    wr(ppu_pkg::ADDR_CTRL, 32'h5);
    settle(2);
    chk("busy_pin", 1'b1, busy_pin);
    rd(ppu_pkg::ADDR_STAT, 32'h10, 32'h10);
    // Status lines change only a full microsecond into the error cycle
    settle(100);
    wr(ppu_pkg::ADDR_IO, 32'h0800);
    d = 8'($urandom);
    host.send(d, 1'b1, 4);
    rd(ppu_pkg::ADDR_IO, 32'h1FF, {23'h0, 1'b1, d});
    ack_chk(1'b0);
    chk("busy_pin", 1'b1, busy_pin);
    wr(ppu_pkg::ADDR_IO, 32'h0);
    settle(100);
    wr(ppu_pkg::ADDR_CTRL, 32'h1);
    ack_chk(1'b1);
    settle(3);
    chk("busy_pin", 1'b0, busy_pin);
    host.send(8'($urandom), 1'b1, 4);
    chk("dma_req", 1'b1, dma_req);
    wr(ppu_pkg::ADDR_CTRL, 32'h20);
    settle(2);
    chk("busy_pin", 1'b0, busy_pin);
    chk("dma_req", 1'b0, dma_req);
    wr(ppu_pkg::ADDR_CTRL, 32'h10);
    d = 8'($urandom);
    host.send(d, 1'b1, 4);
    host.send(~d, 1'b1, 1);
    rd(ppu_pkg::ADDR_IO, 32'h0FF, {24'h0, d});
    wr(ppu_pkg::ADDR_CTRL, 32'h8);
    host.send(~d, 1'b1, 4);
    rd(ppu_pkg::ADDR_IO, 32'h0FF, {24'h0, d});
    wr(ppu_pkg::ADDR_CTRL, 32'h0);
    host.send(~d, 1'b1, 1);
    rd(ppu_pkg::ADDR_IO, 32'h0FF, {24'h0, ~d});
    settle(3);
    summarize();
  end
endmodule : ppu_core_tb
`default_nettype wire

/* bench/ppu_host.sv */
// Host computer model driving the printer-side control and data pins
`timescale 1ns/100ps
`default_nettype none
module ppu_host (
  input wire logic sys_clk,
  output logic strobe_n,
  output logic autofd_n,
  output logic init_n,
  output logic selectin_n,
  output logic [7:0] pdata
);
  initial
  begin
    strobe_n = 1'b1;
    autofd_n = 1'b1;
    init_n = 1'b1;
    selectin_n = 1'b1;
    pdata = 8'h00;
  end
  // Data held while strobe is low, then scrambled so a late latch is caught
  task automatic send(input logic [7:0] d, input logic af, input int low);
    begin
      @(posedge sys_clk);
      pdata <= d;
      autofd_n <= af;
      repeat (2) @(posedge sys_clk);
      strobe_n <= 1'b0;
      repeat (low) @(posedge sys_clk);
      strobe_n <= 1'b1;
      // Data outlasts strobe long enough for the slowest latch path
      repeat (3) @(posedge sys_clk);
      pdata <= ~d;
      repeat (2) @(posedge sys_clk);
    end
  endtask : send
endmodule : ppu_host
`default_nettype wire

/* core/ppu_core.sv */
// Parallel port input unit: synchronisers, filters, data latch, handshake
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Mode 00 runs no handshake, yet strobe leading edge still latches data.
// - Host control inputs pass two flops; data lines are taken directly.
// - Unfiltered inputs reach status bits within one clock of synchronising.
// - Busy and ack pins follow software bits while the controller idles.
// - Status shows the four control input levels; IO register bits drive select, perror and fault.
// - Optional filter on selectin, strobe, autofd, init, independent of mode.
// - Filter passes a level only after two equal consecutive samples.
// - Filtering adds one clock, so busy answers strobe one clock later.
// - Data and autofd latch one clock later when the filter is on.
// - Setting the error-cycle bit sets hardware busy at once.
// - Clearing the error-cycle bit gives an ack pulse, then clears hardware busy if software bits are clear.
// - Strobe during error cycle still latches; ack withheld, busy held.
// - An ack pulse already running is not cut by the error-cycle bit.
// - Latch on every filtered strobe fall in any mode unless disabled.
// - Reset clears all register bits except software busy and the control input flops, which set.
// - State-machine reset idles controller, ends decompression, drops DMA request.
// - Idle negates busy and ack; clear software bits give busy 0, ack 1.
// - State-machine reset clears run-length pending and fill flags.
// - Mode 01 compatibility, 10 ECP, 11 ECP with run-length decoding.
module ppu_core (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic strobe_n_pin,
  input wire logic autofd_n_pin,
  input wire logic init_n_pin,
  input wire logic selectin_n_pin,
  input wire logic [7:0] pdata_pin,
  output logic busy_pin,
  output logic ack_n_pin,
  output logic select_pin,
  output logic perror_pin,
  output logic fault_n_pin,
  output logic dma_req
);
  // ****************************************************************
  // Register bus decode
  // ****************************************************************
  wire logic wr_io = reg_wr && (reg_addr == ppu_pkg::ADDR_IO);
  wire logic wr_ctrl = reg_wr && (reg_addr == ppu_pkg::ADDR_CTRL);
  wire logic rd_io = reg_rd && (reg_addr == ppu_pkg::ADDR_IO);
  wire logic sm_rst = wr_ctrl && reg_wdata[ppu_pkg::CTRL_SMRST];

  logic [8:0] data_r;
  logic sw_busy_r, sw_ack_r, sel_r, perr_r, fault_r;
  logic [1:0] mode_r;
  logic erc_r, ldis_r, filt_en_r, rlpend_r, fill_r;
  logic hw_busy_r, hw_ack_r, full_r;
  logic [7:0] cnt_r;
  ppu_pkg::ppu_state_t st_r;

  // ****************************************************************
  // Synchronisers and filters
  // ****************************************************************
  ppu_pkg::ppu_ctl_t pin_w, sync1_r, sync2_r, samp_r, filt_r, cur_w, prev_r;
  logic [3:0] filt_nxt;
  assign pin_w = '{selectin: selectin_n_pin, init: init_n_pin,
                   autofd: autofd_n_pin, strobe: strobe_n_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_filt
      // Two equal samples in a row move the output
      assign filt_nxt[gi] = (sync2_r[gi] == samp_r[gi]) ? sync2_r[gi] : filt_r[gi];
    end
  endgenerate

  // One enable for all four keeps their relative timing intact
  // Filter output is taken ahead of its flop, so filtering costs one clock, not two
  assign cur_w = filt_en_r ? ppu_pkg::ppu_ctl_t'(filt_nxt) : sync2_r;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sync1_r <= ppu_pkg::CTL_IDLE;
      sync2_r <= ppu_pkg::CTL_IDLE;
      samp_r <= ppu_pkg::CTL_IDLE;
      filt_r <= ppu_pkg::CTL_IDLE;
      prev_r <= ppu_pkg::CTL_IDLE;
    end
    else
    begin
      sync1_r <= pin_w;
      sync2_r <= sync1_r;
      samp_r <= sync2_r;
      filt_r <= filt_nxt;
      prev_r <= cur_w;
    end
  end

  wire logic stb_fall = prev_r.strobe && !cur_w.strobe;
  wire logic stb_high = cur_w.strobe;
  // Data lines are steady while strobe is low, so no sync is needed
  wire logic do_latch = stb_fall && !ldis_r;
  wire logic is_cmd = !cur_w.autofd;
  wire logic rl_cmd = do_latch && (mode_r == ppu_pkg::MODE_ECPRLE) && is_cmd
                      && !pdata_pin[ppu_pkg::DATA_MSB];

  // ****************************************************************
  // Handshake controller
  // ****************************************************************
  ppu_pkg::ppu_state_t st_nxt;
  logic [7:0] cnt_nxt;
  wire logic cnt_done = (cnt_r == 8'h00);

  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      ppu_pkg::ST_IDLE:
      begin
        if (erc_r)
          st_nxt = ppu_pkg::ST_ERR;
        else if (do_latch && mode_r == ppu_pkg::MODE_COMPAT)
          st_nxt = ppu_pkg::ST_BUSY;
        else if (rd_io && full_r && mode_r[1])
          st_nxt = ppu_pkg::ST_ECP;
      end
      ppu_pkg::ST_BUSY:
      begin
        if (erc_r)
          st_nxt = ppu_pkg::ST_ERR;
        else if (stb_high && !full_r)
        begin
          st_nxt = ppu_pkg::ST_ACK;
          cnt_nxt = ppu_pkg::ACK_CNT;
        end
      end
      ppu_pkg::ST_ACK:
      begin
        // The error bit does not shorten a pulse once started
        if (cnt_done)
          st_nxt = erc_r ? ppu_pkg::ST_ERR : ppu_pkg::ST_IDLE;
        else
          cnt_nxt = cnt_r - 8'h01;
      end
      ppu_pkg::ST_ERR:
      begin
        if (!erc_r)
        begin
          st_nxt = ppu_pkg::ST_ACK;
          cnt_nxt = ppu_pkg::ACK_CNT;
        end
      end
      ppu_pkg::ST_ECP:
      begin
        if (stb_high)
          st_nxt = ppu_pkg::ST_IDLE;
      end
      default:
        st_nxt = ppu_pkg::ST_IDLE;
    endcase
    if (sm_rst)
      st_nxt = ppu_pkg::ST_IDLE;
  end

  wire logic hs_busy = (st_nxt != ppu_pkg::ST_IDLE);
  wire logic idle_clr = !sw_busy_r && !sw_ack_r;
  wire logic hw_busy_nxt = erc_r || hs_busy || (hw_busy_r && !idle_clr);
  wire logic hw_ack_nxt = (st_nxt == ppu_pkg::ST_ACK) ? 1'b0 :
                          (hs_busy || idle_clr) ? 1'b1 : hw_ack_r;
  // Software bits drive the pins only while the controller idles
  wire logic idle_nxt = (st_nxt == ppu_pkg::ST_IDLE);
  wire logic busy_nxt = idle_nxt ? sw_busy_r : 1'b1;
  wire logic ack_nxt = idle_nxt ? !sw_ack_r : (st_nxt != ppu_pkg::ST_ACK);

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      data_r <= '0;
      sw_busy_r <= ppu_pkg::SWBUSY_RST;
      sw_ack_r <= 1'b0;
      sel_r <= 1'b0;
      perr_r <= 1'b0;
      fault_r <= 1'b0;
      mode_r <= ppu_pkg::MODE_OFF;
      erc_r <= 1'b0;
      ldis_r <= 1'b0;
      filt_en_r <= 1'b0;
      rlpend_r <= 1'b0;
      fill_r <= 1'b0;
      hw_busy_r <= 1'b0;
      hw_ack_r <= 1'b0;
      full_r <= 1'b0;
      cnt_r <= 8'h00;
      st_r <= ppu_pkg::ST_IDLE;
    end
    else
    begin
      if (do_latch)
        data_r <= {cur_w.autofd, pdata_pin};
      if (wr_io)
      begin
        sw_busy_r <= reg_wdata[ppu_pkg::IO_SWBUSY];
        sw_ack_r <= reg_wdata[ppu_pkg::IO_SWACK];
        sel_r <= reg_wdata[ppu_pkg::IO_SEL];
        perr_r <= reg_wdata[ppu_pkg::IO_PERR];
        fault_r <= reg_wdata[ppu_pkg::IO_FAULT];
      end
      if (wr_ctrl)
      begin
        mode_r <= reg_wdata[ppu_pkg::CTRL_MODE_LSB +: 2];
        erc_r <= reg_wdata[ppu_pkg::CTRL_ERC];
        ldis_r <= reg_wdata[ppu_pkg::CTRL_LDIS];
        filt_en_r <= reg_wdata[ppu_pkg::CTRL_FILT];
      end
      // A new byte wins over a read in the same cycle
      full_r <= !sm_rst && (do_latch || (full_r && !rd_io));
      rlpend_r <= !sm_rst && (rl_cmd || rlpend_r);
      fill_r <= !sm_rst && (rl_cmd || fill_r);
      hw_busy_r <= hw_busy_nxt;
      hw_ack_r <= hw_ack_nxt;
      cnt_r <= cnt_nxt;
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Pins and read data
  // ****************************************************************
  wire logic [31:0] io_w = {18'h0, fault_r, perr_r, sel_r, sw_ack_r, sw_busy_r, data_r};
  wire logic [31:0] ctrl_w = {20'h0, cur_w, fill_r, rlpend_r, 1'b0, filt_en_r,
                              ldis_r, erc_r, mode_r};
  wire logic [31:0] stat_w = {26'h0, hw_ack_r, hw_busy_r, cur_w};
  wire logic [31:0] rd_w = (reg_addr == ppu_pkg::ADDR_IO) ? io_w :
                           (reg_addr == ppu_pkg::ADDR_CTRL) ? ctrl_w :
                           (reg_addr == ppu_pkg::ADDR_STAT) ? stat_w : 32'h0;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      reg_rdata <= 32'h0;
      busy_pin <= 1'b0;
      ack_n_pin <= 1'b1;
      select_pin <= 1'b0;
      perror_pin <= 1'b0;
      fault_n_pin <= 1'b1;
      dma_req <= 1'b0;
    end
    else
    begin
      reg_rdata <= reg_rd ? rd_w : 32'h0;
      busy_pin <= busy_nxt;
      ack_n_pin <= ack_nxt;
      select_pin <= sel_r;
      perror_pin <= perr_r;
      fault_n_pin <= !fault_r;
      dma_req <= !sm_rst && (mode_r != ppu_pkg::MODE_OFF)
                 && (do_latch || (full_r && !rd_io));
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_ack_start;
    (st_r == ppu_pkg::ST_ACK) ##1 !ack_n_pin;
  endsequence
  property p_latch;
    @(posedge sys_clk) disable iff (rst) do_latch |=> data_r[7:0] == $past(pdata_pin);
  endproperty
  a_latch: assert property (p_latch) else $error("data not latched");
  property p_erc_busy;
    @(posedge sys_clk) disable iff (rst) erc_r |=> hw_busy_r;
  endproperty
  a_erc_busy: assert property (p_erc_busy) else $error("busy not set");
  property p_noack;
    @(posedge sys_clk) disable iff (rst)
      erc_r && st_r != ppu_pkg::ST_ACK && !sw_ack_r |=> ##1 ack_n_pin || st_r == ppu_pkg::ST_ACK;
  endproperty
  a_noack: assert property (p_noack) else $error("ack during error");
  property p_erc_clear;
    @(posedge sys_clk) disable iff (rst)
      st_r == ppu_pkg::ST_ERR && !erc_r && !sm_rst |=> s_ack_start;
  endproperty
  a_erc_clear: assert property (p_erc_clear) else $error("no ack after error");
  property p_smrst;
    @(posedge sys_clk) disable iff (rst)
      sm_rst |=> st_r == ppu_pkg::ST_IDLE && !rlpend_r && !fill_r && !dma_req;
  endproperty
  a_smrst: assert property (p_smrst) else $error("sm reset failed");
  property p_idle;
    @(posedge sys_clk) disable iff (rst)
      st_nxt == ppu_pkg::ST_IDLE && idle_clr && !erc_r |=> !hw_busy_r && hw_ack_r;
  endproperty
  a_idle: assert property (p_idle) else $error("idle bits wrong");
  property p_sw;
    @(posedge sys_clk) disable iff (rst)
      st_nxt == ppu_pkg::ST_IDLE |=> busy_pin == $past(sw_busy_r);
  endproperty
  a_sw: assert property (p_sw) else $error("busy not following software");
  property p_filt;
    @(posedge sys_clk) disable iff (rst)
      filt_r.strobe != $past(filt_r.strobe) |-> $past(sync2_r.strobe) == $past(samp_r.strobe);
  endproperty
  a_filt: assert property (p_filt) else $error("filter passed glitch");
  property p_mode0;
    @(posedge sys_clk) disable iff (rst)
      mode_r == ppu_pkg::MODE_OFF && st_r == ppu_pkg::ST_IDLE && !erc_r |=> st_r == ppu_pkg::ST_IDLE;
  endproperty
  a_mode0: assert property (p_mode0) else $error("handshake in mode 00");
  property p_sync_lag;
    @(posedge sys_clk) disable iff (rst)
      !filt_en_r |-> cur_w.strobe == $past(strobe_n_pin, 2);
  endproperty
  a_sync_lag: assert property (p_sync_lag) else $error("sync path delay wrong");
  property p_filt_lag;
    @(posedge sys_clk) disable iff (rst)
      filt_en_r && $past(strobe_n_pin, 3) == $past(strobe_n_pin, 2)
      |-> cur_w.strobe == $past(strobe_n_pin, 2);
  endproperty
  a_filt_lag: assert property (p_filt_lag) else $error("filter delay wrong");
  property p_busy_compat;
    @(posedge sys_clk) disable iff (rst)
      st_r == ppu_pkg::ST_IDLE && mode_r == ppu_pkg::MODE_COMPAT
      && do_latch && !erc_r && !sm_rst |=> busy_pin;
  endproperty
  a_busy_compat: assert property (p_busy_compat) else $error("busy late after strobe");
  property p_ldis;
    @(posedge sys_clk) disable iff (rst) ldis_r |=> data_r == $past(data_r);
  endproperty
  a_ldis: assert property (p_ldis) else $error("latched while disabled");
  property p_hold_ack;
    @(posedge sys_clk) disable iff (rst)
      st_r == ppu_pkg::ST_ACK && !cnt_done && !sm_rst |=> st_r == ppu_pkg::ST_ACK;
  endproperty
  a_hold_ack: assert property (p_hold_ack) else $error("ack pulse cut short");
endmodule : ppu_core
`default_nettype wire

/* core/ppu_pkg.sv */
// Constants, field layout and types for the parallel port input unit
package ppu_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] ADDR_IO = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  // Port I/O register fields
  localparam int IO_DATA_LSB = 0;
  localparam int IO_DATA_W = 9;
  localparam int IO_CMD = 8;
  localparam int IO_SWBUSY = 9;
  localparam int IO_SWACK = 10;
  localparam int IO_SEL = 11;
  localparam int IO_PERR = 12;
  localparam int IO_FAULT = 13;
  // Port control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ERC = 2;
  localparam int CTRL_LDIS = 3;
  localparam int CTRL_FILT = 4;
  localparam int CTRL_SMRST = 5;
  localparam int CTRL_RLPEND = 6;
  localparam int CTRL_FILL = 7;
  localparam int CTRL_LVL_LSB = 8;
  // Event/status register fields
  localparam int STAT_LVL_LSB = 0;
  localparam int STAT_HWBUSY = 4;
  localparam int STAT_HWACK = 5;
  localparam int DATA_MSB = 7;
  // ****************************************************************
  // Modes, reset values, timing
  // ****************************************************************
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_COMPAT = 2'h1;
  localparam logic [1:0] MODE_ECP = 2'h2;
  localparam logic [1:0] MODE_ECPRLE = 2'h3;
  localparam logic [3:0] CTL_IDLE = 4'hF;
  localparam logic SWBUSY_RST = 1'b1;
  localparam int CLK_NS = 10;
  localparam int ACK_NS = 500;
  localparam int ACK_CYC = (ACK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] ACK_CNT = 8'(ACK_CYC - 1);
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic selectin;
    logic init;
    logic autofd;
    logic strobe;
  } ppu_ctl_t;
  typedef enum logic [2:0] {ST_IDLE, ST_BUSY, ST_ACK, ST_ERR, ST_ECP} ppu_state_t;
endpackage : ppu_pkg
